/* File: exec_pkg.sv */
// shared constants and types for the skip and table-read execution block
package exec_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int PC_W = 10;
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int HIGH_W = WORD_W - DATA_W;
    localparam int PAGE_W = PC_W - DATA_W;
    // ************************************************************
    // constants
    // ************************************************************
    localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [HIGH_W-1:0] HIGH_RESET = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;

    typedef enum logic [1:0] {
        OP_OTHER,
        OP_SKIP_IF_BIT_ZERO,
        OP_TABLE_READ_CURRENT_PAGE,
        OP_TABLE_READ_LAST_PAGE
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SKIP,
        ST_TABLE
    } state_e;
endpackage

/* File: exec_if.sv */
// carrier between the sequencer and its table-address helper
interface exec_if;
    import exec_pkg::*;
    logic last_page;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] pointer;
    logic [PC_W-1:0] table_addr;
    modport seq (output last_page, output pc, output pointer, input table_addr);
    modport addr (input last_page, input pc, input pointer, output table_addr);
endinterface

/* File: table_addr_gen.sv */
// forms the program-memory address of a table read
module table_addr_gen (
    exec_if.addr bus
);
    import exec_pkg::*;
    // ************************************************************
    // address: page bits from pc or the last page, low byte from pointer
    // ************************************************************
    always_comb begin
        if (bus.last_page) begin
            bus.table_addr = {LAST_PAGE, bus.pointer};
        end else begin
            bus.table_addr = {bus.pc[PC_W-1:DATA_W], bus.pointer};
        end
    end
endmodule // table_addr_gen

/* File: bit_skip_and_table_read_exec.sv */
// execution sequencer for bit-test skip and the two table reads
// Overview of operation
// - bit-test skip reads the chosen bit of data memory; zero means skip next.
// - a taken skip inserts a dummy cycle while next fetches; two cycles total.
// - a nonzero bit lets the following instruction run normally.
// - current-page table read fetches pc page plus pointer, low byte to memory.
// - current-page table read puts the high byte into the table-high register.
// - last-page table read fetches last page plus pointer, low byte to memory.
module bit_skip_and_table_read_exec (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic issue_in,
    input wire exec_pkg::op_e op_in,
    input wire logic [exec_pkg::ADDR_W-1:0] mem_addr_in,
    input wire logic [exec_pkg::BIT_W-1:0] bit_sel_in,
    input wire logic [exec_pkg::PC_W-1:0] pc_in,
    input wire logic [exec_pkg::DATA_W-1:0] table_pointer_reg_in,
    input wire logic [exec_pkg::DATA_W-1:0] dmem_rdata_in,
    input wire logic [exec_pkg::WORD_W-1:0] pmem_rdata_in,
    output logic busy_out,
    output logic squash_out,
    output logic done_out,
    output logic [exec_pkg::ADDR_W-1:0] dmem_raddr_out,
    output logic [exec_pkg::PC_W-1:0] pmem_addr_out,
    output logic pmem_rd_out,
    output logic dmem_we_out,
    output logic [exec_pkg::ADDR_W-1:0] dmem_waddr_out,
    output logic [exec_pkg::DATA_W-1:0] dmem_wdata_out,
    output logic [exec_pkg::HIGH_W-1:0] table_high_byte_reg_out
);
    import exec_pkg::*;

    // ************************************************************
    // address helper
    // ************************************************************
    exec_if tbus ();
    assign tbus.last_page = (op_in == OP_TABLE_READ_LAST_PAGE);
    assign tbus.pc = pc_in;
    assign tbus.pointer = table_pointer_reg_in;

    table_addr_gen u_addr (
        .bus(tbus)
    );

    // ************************************************************
    // state
    // ************************************************************
    state_e state;
    state_e next_state;
    logic start_skip;
    logic start_table;
    logic next_busy;
    logic next_done;

    // an op is taken only from idle; an issue while busy is simply dropped
    always_comb begin
        start_skip = 1'b0;
        start_table = 1'b0;
        if (state == ST_IDLE && issue_in) begin
            unique case (op_in)
                OP_SKIP_IF_BIT_ZERO: begin
                    start_skip = 1'b1;
                end
                OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
                    start_table = 1'b1;
                end
                // other opcodes pass through: nothing is shown for them
                OP_OTHER: begin
                    start_table = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // sequencer: every accepted op takes exactly two cycles
    // ************************************************************
    // the next issue may come at the edge after done rises: busy is low by
    // then, so back-to-back ops run every two cycles
    always_comb begin
        next_state = state;
        next_busy = busy_out;
        next_done = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (start_skip) begin
                    next_state = ST_SKIP;
                    next_busy = 1'b1;
                end else if (start_table) begin
                    next_state = ST_TABLE;
                    next_busy = 1'b1;
                end
            end
            ST_SKIP, ST_TABLE: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            state <= next_state;
            busy_out <= next_busy;
            done_out <= next_done;
        end
    end

    // ************************************************************
    // bit-test skip
    // ************************************************************
    logic [BIT_W-1:0] bit_sel;
    logic [BIT_W-1:0] next_bit_sel;
    logic [ADDR_W-1:0] next_dmem_raddr;
    logic next_squash;
    logic [DATA_W-1:0] bit_hit;
    logic tested_bit;

    // flat and-or pick of the chosen bit; data memory answers in the same cycle
    // that the address is registered, so the pick is used in the busy cycle
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit_pick
        assign bit_hit[i] = dmem_rdata_in[i] & (bit_sel == BIT_W'(i));
    end
    assign tested_bit = |bit_hit;

    // bit index held from issue since the bit input may move on meanwhile
    always_comb begin
        next_bit_sel = bit_sel;
        next_dmem_raddr = dmem_raddr_out;
        next_squash = 1'b0;
        if (start_skip) begin
            next_bit_sel = bit_sel_in;
            next_dmem_raddr = mem_addr_in;
        end
        if (state == ST_SKIP) begin
            // zero bit: following fetch becomes a dummy; else it proceeds
            next_squash = ~tested_bit;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_sel <= '0;
            dmem_raddr_out <= ADDR_RESET;
            squash_out <= 1'b0;
        end else begin
            bit_sel <= next_bit_sel;
            dmem_raddr_out <= next_dmem_raddr;
            squash_out <= next_squash;
        end
    end

    // ************************************************************
    // table read: program fetch, both pages share one path
    // ************************************************************
    logic [ADDR_W-1:0] dest;
    logic [ADDR_W-1:0] next_dest;
    logic [PC_W-1:0] next_pmem_addr;
    logic next_pmem_rd;

    // program memory answers in the same cycle as the strobe; the helper picks the page
    always_comb begin
        next_dest = dest;
        next_pmem_addr = pmem_addr_out;
        next_pmem_rd = 1'b0;
        if (start_table) begin
            next_dest = mem_addr_in;
            next_pmem_addr = tbus.table_addr;
            next_pmem_rd = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dest <= ADDR_RESET;
            pmem_addr_out <= PC_RESET;
            pmem_rd_out <= 1'b0;
        end else begin
            dest <= next_dest;
            pmem_addr_out <= next_pmem_addr;
            pmem_rd_out <= next_pmem_rd;
        end
    end

    // ************************************************************
    // table read: write-back of the fetched word
    // ************************************************************
    logic next_dmem_we;
    logic [ADDR_W-1:0] next_dmem_waddr;
    logic [DATA_W-1:0] next_dmem_wdata;
    logic [HIGH_W-1:0] next_high;

    // address and data stay after the strobe so a slow consumer may look late
    always_comb begin
        next_dmem_we = 1'b0;
        next_dmem_waddr = dmem_waddr_out;
        next_dmem_wdata = dmem_wdata_out;
        next_high = table_high_byte_reg_out;
        if (state == ST_TABLE) begin
            next_dmem_we = 1'b1;
            next_dmem_waddr = dest;
            next_dmem_wdata = pmem_rdata_in[DATA_W-1:0];
            // flags untouched: this block drives no status flags
            next_high = pmem_rdata_in[WORD_W-1:DATA_W];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dmem_we_out <= 1'b0;
            dmem_waddr_out <= ADDR_RESET;
            dmem_wdata_out <= DATA_RESET;
            table_high_byte_reg_out <= HIGH_RESET;
        end else begin
            dmem_we_out <= next_dmem_we;
            dmem_waddr_out <= next_dmem_waddr;
            dmem_wdata_out <= next_dmem_wdata;
            table_high_byte_reg_out <= next_high;
        end
    end
endmodule // bit_skip_and_table_read_exec

/* File: exec_chk.sv */
// assertion checker for the skip and table-read execution block
module exec_chk import exec_pkg::*; (
    input wire logic clk_sys_in, rstn_in, issue_in, busy_out, squash_out, done_out,
    input wire op_e op_in,
    input wire logic [ADDR_W-1:0] mem_addr_in, dmem_raddr_out, dmem_waddr_out,
    input wire logic [BIT_W-1:0] bit_sel_in,
    input wire logic [PC_W-1:0] pc_in, pmem_addr_out,
    input wire logic [DATA_W-1:0] table_pointer_reg_in, dmem_rdata_in, dmem_wdata_out,
    input wire logic [WORD_W-1:0] pmem_rdata_in,
    input wire logic pmem_rd_out, dmem_we_out,
    input wire logic [HIGH_W-1:0] table_high_byte_reg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic [BIT_W-1:0] sel;
    logic [ADDR_W-1:0] dest;
    op_e kind;
    assign take = issue_in && !busy_out && op_in != OP_OTHER;
    // operands kept from the issue edge so the checks need no deep history
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel <= '0;
            dest <= '0;
            kind <= OP_OTHER;
        end else if (take) begin
            sel <= bit_sel_in;
            dest <= mem_addr_in;
            kind <= op_in;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_skip_addr: assert property (
        take && op_in == OP_SKIP_IF_BIT_ZERO |=> busy_out && dmem_raddr_out == dest)
        else $error("skip read address wrong");
    a_skip_bit: assert property (
        done_out && kind == OP_SKIP_IF_BIT_ZERO |-> squash_out == !$past(dmem_rdata_in[sel]))
        else $error("skip decision wrong");
    a_squash_two: assert property (
        squash_out |-> done_out && $past(busy_out) && kind == OP_SKIP_IF_BIT_ZERO)
        else $error("squash outside a skip");
    a_cur_addr: assert property (
        take && op_in == OP_TABLE_READ_CURRENT_PAGE |=> pmem_rd_out
        && pmem_addr_out == {$past(pc_in[PC_W-1:DATA_W]), $past(table_pointer_reg_in)})
        else $error("current page address wrong");
    a_last_addr: assert property (
        take && op_in == OP_TABLE_READ_LAST_PAGE |=> pmem_rd_out
        && pmem_addr_out == {LAST_PAGE, $past(table_pointer_reg_in)})
        else $error("last page address wrong");
    a_low_write: assert property (
        pmem_rd_out |=> done_out && dmem_we_out && dmem_waddr_out == dest
        && dmem_wdata_out == $past(pmem_rdata_in[DATA_W-1:0]))
        else $error("low byte write wrong");
    a_high_byte: assert property (
        pmem_rd_out |=> table_high_byte_reg_out == $past(pmem_rdata_in[WORD_W-1:DATA_W]))
        else $error("table high byte wrong");
    a_two_cycle: assert property (
        take |=> busy_out ##1 (!busy_out && done_out))
        else $error("op not two cycles long");
endmodule // exec_chk
bind bit_skip_and_table_read_exec exec_chk chk (.*);

/* File: exec_mem_model.sv */
// behavioural program and data memories facing the block
module exec_mem_model import exec_pkg::*; (
    input wire logic [ADDR_W-1:0] dmem_raddr_in,
    input wire logic [PC_W-1:0] pmem_addr_in,
    input wire logic pmem_rd_in,
    output logic [DATA_W-1:0] dmem_rdata_out,
    output logic [WORD_W-1:0] pmem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] word;
    assign word = {pmem_addr_in, 4'h9} ^ 14'h1A5C;
    assign dmem_rdata_out = {dmem_raddr_in, dmem_raddr_in[0]} ^ 8'h5A;
    // word only valid while the strobe stands; otherwise its inverse
    assign pmem_rdata_out = pmem_rd_in ? word : ~word;
endmodule // exec_mem_model

/* File: bit_skip_and_table_read_exec_tb.sv */
// self-checking bench for the skip and table-read execution block
module bit_skip_and_table_read_exec_tb import exec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 0, rstn_in = 0, issue_in = 0, busy_out, squash_out, done_out;
    logic pmem_rd_out, dmem_we_out;
    op_e op_in = OP_OTHER;
    logic [ADDR_W-1:0] mem_addr_in = '0, dmem_raddr_out, dmem_waddr_out;
    logic [BIT_W-1:0] bit_sel_in = '0;
    logic [PC_W-1:0] pc_in = '0, pmem_addr_out, a;
    logic [DATA_W-1:0] table_pointer_reg_in = '0, dmem_rdata_in, dmem_wdata_out, d;
    logic [WORD_W-1:0] pmem_rdata_in, w;
    logic [HIGH_W-1:0] table_high_byte_reg_out, high = '0;
    logic [31:0] r;
    logic [22:0] got;
    logic [22:0] notes[$];
    int errors = 0, comparisons = 0, cycles = 0, seed = 33265;
    bit_skip_and_table_read_exec dut (.*);
    exec_mem_model mem (.dmem_raddr_in(dmem_raddr_out), .pmem_addr_in(pmem_addr_out),
        .pmem_rd_in(pmem_rd_out), .dmem_rdata_out(dmem_rdata_in), .pmem_rdata_out(pmem_rdata_in));
    always #10 clk_sys_in = ~clk_sys_in;
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(string name, logic [13:0] exp, logic [13:0] seen);
        comparisons++;
        if (exp !== seen) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end
    // one note per accepted op, taken off when done shows
    always @(posedge clk_sys_in) begin
        if (rstn_in && done_out === 1'b1) begin
            got = notes.pop_front();
            cmp("squash", got[22], squash_out);
            cmp("we", got[21], dmem_we_out);
            if (got[21]) cmp("wdata", got[20:13], dmem_wdata_out);
            if (got[21]) cmp("waddr", got[12:6], dmem_waddr_out);
            cmp("high", got[5:0], table_high_byte_reg_out);
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rstn_in <= 1;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk_sys_in);
            r = $random(seed);
            d = {r[11:5], r[5]} ^ 8'h5A;
            a = {(r[1:0] == 2'h2) ? r[29:28] : LAST_PAGE, r[19:12]};
            w = {a, 4'h9} ^ 14'h1A5C;
            if (r[1:0] == 2'h1) notes.push_back({~d[r[4:2]], 1'b0, 8'h00, 7'h00, high});
            if (r[1]) high = w[13:8];
            if (r[1]) notes.push_back({1'b0, 1'b1, w[7:0], r[11:5], high});
            issue_in <= 1;
            op_in <= op_e'(r[1:0]);
            bit_sel_in <= r[4:2];
            mem_addr_in <= r[11:5];
            table_pointer_reg_in <= r[19:12];
            pc_in <= r[29:20];
            @(posedge clk_sys_in);
            // at times held into the busy cycle, where it must be ignored
            issue_in <= r[30];
            @(posedge clk_sys_in);
            issue_in <= 0;
        end
        repeat (3) @(posedge clk_sys_in);
        cmp("pending", 14'h0000, 14'(notes.size()));
        give_verdict();
    end
endmodule // bit_skip_and_table_read_exec_tb
